// ---- rtl/dcw_config_word.sv ----
// device configuration word loader and decoder
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps

// Overview of operation
// - permit bits grant debug access per group
// - denied group becomes group 3 in debug
// - flash sleep bit or regulator standby powers down
// - boot isa 1: standard set, flag 0
// - boot isa 0: compressed set, flag 1
// - trace bit enables cpu trace features
// - channel code selects debug pin pair
// - fuse scan enable copied at reset
// - fuse zero blocks setting run-time enable
// - fuse one lets software toggle enable
// - debugger select field decodes port enables
// - code protect forces debugger select 11
// - either enable zero blocks four-wire only
module dcw_config_word
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [31:0] cfgWordIn,
   input wire logic codeProtectEn,
   input wire logic cpuDebugMode,
   input wire logic [1:0] cpuPermissionGroupSel,
   input wire logic regulatorStandbyCtrl,
   input wire logic sleepMode,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   output logic [1:0] busPermissionGroup,
   output logic flashPowerDown,
   output dcw_pkg::dcw_decode_s decodeOut
);

   // behaviour notes for integrators:
   // the word and the code protect level are taken on the second edge
   // after reset release, so the store must be settled by then
   // nothing re-reads the word until the next reset; the word offset
   // is read-only and writes to it vanish without effect
   // decode outputs stay all zero until the word is in, so the core
   // sees no trace, no debug unit and no pin pair during that window
   // code protection reads as high while in reset, which keeps the
   // debug select forced to four-wire only until the real level is in
   // the tool-owned bit and the reserved ones are only reported, never
   // acted on, since software and the programmer own them
   // group remap and flash power-down are combinational, so a change
   // of debug mode or sleep takes effect in the same cycle

   // load sequencing: capture on the second edge after reset release
   typedef enum logic [1:0]
   {
      DCW_IDLE = 2'b00,
      DCW_LOAD = 2'b01,
      DCW_HELD = 2'b10
   } dcw_state_e;

   dcw_state_e state_reg;
   dcw_state_e state_next;
   logic [31:0] cfgWord_reg;
   logic [31:0] cfgWord_next;
   logic cpSticky_reg;
   logic cpSticky_next;
   logic scanEn_reg;
   logic scanEn_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   dcw_pkg::dcw_decode_s decode_reg;
   dcw_pkg::dcw_decode_s decode_next;

   // field views of the held word; only the held copy is ever decoded,
   // so a late wobble on the store input cannot leak through
   // debug access and flash power
   wire logic [2:0] permitField = cfgWord_reg[dcw_pkg::DBG_PERMIT_HI:dcw_pkg::DBG_PERMIT_LO];
   wire logic flashSleepBit = cfgWord_reg[dcw_pkg::FLASH_SLEEP_BIT];

   // boot instruction set and trace
   wire logic bootIsaBit = cfgWord_reg[dcw_pkg::BOOT_ISA_BIT];
   wire logic traceBit = cfgWord_reg[dcw_pkg::TRACE_EN_BIT];

   // debug port routing and scan fuse
   wire logic [1:0] chanField = cfgWord_reg[dcw_pkg::CHAN_SEL_HI:dcw_pkg::CHAN_SEL_LO];
   wire logic scanFuseBit = cfgWord_reg[dcw_pkg::SCAN_FUSE_BIT];
   wire logic [1:0] dbgSelRaw = cfgWord_reg[dcw_pkg::DBG_SEL_HI:dcw_pkg::DBG_SEL_LO];

   // bits kept for reporting only
   wire logic [2:0] rsvdOnes = cfgWord_reg[dcw_pkg::RSVD_ONES_HI:dcw_pkg::RSVD_ONES_LO];
   wire logic toolBit = cfgWord_reg[dcw_pkg::TOOL_RSVD_BIT];

   // load done flag shared by every consumer
   wire logic loaded = (state_reg == DCW_HELD);

   // pin pair decode, one-hot in pair order 3..1
   // the reserved code routes to no pair at all rather than a guess
   function automatic logic [2:0] chan_decode(input logic [1:0] code);
      logic [2:0] pairs;
      pairs = 3'h0;
      case (code)
         dcw_pkg::DCW_CHAN_PAIR1: pairs = 3'h1;
         dcw_pkg::DCW_CHAN_PAIR2: pairs = 3'h2;
         dcw_pkg::DCW_CHAN_PAIR3: pairs = 3'h4;
         default: pairs = 3'h0;
      endcase
      return pairs;
   endfunction

   // permit check shared by debug-mode group remapping
   // group 3 has no permit bit, so it is never reported as permitted
   function automatic logic group_permitted(input logic [2:0] permit, input logic [1:0] grp);
      logic ok;
      ok = 1'b0;
      if (grp != dcw_pkg::DENIED_GROUP)
      begin
         ok = permit[grp];
      end
      return ok;
   endfunction

   // code protection forces the select to four-wire only
   // forcing also drops the debug unit and the two-wire enable
   wire logic [1:0] dbgSelEff = cpSticky_reg ? dcw_pkg::DBG_SEL_FORCED : dbgSelRaw;
   wire logic fourWireSel = dbgSelEff[1];
   wire logic debugUnitOn = ~dbgSelEff[0];
   // scan port needs both the fuse and the run-time bit
   wire logic fourWireAllowed = fourWireSel & scanFuseBit & scanEn_reg;
   wire logic twoWireAllowed = ~fourWireSel;

   // state sequencing; the word is taken only once per reset
   // one idle cycle first, so the store output has left its reset state
   // before the capture edge; held is final until reset
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         DCW_IDLE: state_next = DCW_LOAD;
         DCW_LOAD: state_next = DCW_HELD;
         DCW_HELD: state_next = DCW_HELD;
         default: state_next = DCW_IDLE;
      endcase
   end

   // capture the word and strap level after release, not under reset
   // code protect is latched with the word so a later change cannot reopen debug
   always_comb
   begin
      cfgWord_next = cfgWord_reg;
      cpSticky_next = cpSticky_reg;
      if (state_reg == DCW_LOAD)
      begin
         cfgWord_next = cfgWordIn;
         cpSticky_next = codeProtectEn;
      end
   end

   // run-time scan enable: copy at load, then software may only clear without fuse
   // writes are ignored before load, so a write racing the reset copy
   // can never win over the fuse value
   wire logic rtWrite = regWrite & (regAddr == dcw_pkg::RT_CTRL_OFS) & loaded;
   wire logic rtWdataBit = regWdata[dcw_pkg::RT_SCAN_EN_BIT];
   always_comb
   begin
      scanEn_next = scanEn_reg;
      if (state_reg == DCW_LOAD)
      begin
         scanEn_next = cfgWordIn[dcw_pkg::SCAN_FUSE_BIT];
      end
      else if (rtWrite)
      begin
         // fuse low pins the bit at zero fuse high writes freely
         scanEn_next = rtWdataBit & scanFuseBit;
      end
   end

   // decode bundle; held at zero until the word is in
   // registered so every consumer sees one settled value per cycle
   always_comb
   begin
      decode_next = '0;
      if (loaded)
      begin
         decode_next.debugAccessPermit = permitField;
         decode_next.flashSleepPowerdown = flashSleepBit;
         decode_next.exceptionInstrSetFlag = ~bootIsaBit;
         decode_next.coreIsaField = bootIsaBit ? dcw_pkg::ISA_STANDARD
                                               : dcw_pkg::ISA_COMPRESSED;
         decode_next.traceEnableBit = traceBit;
         decode_next.twoWireDebugPins = chan_decode(chanField);
         decode_next.chanReserved = (chanField == dcw_pkg::DCW_CHAN_RSVD);
         decode_next.fourWireScanEn = fourWireAllowed;
         decode_next.twoWireEn = twoWireAllowed;
         decode_next.inCircuitDebugUnit = debugUnitOn;
      end
   end

   // denied debug groups fall back to group 3 permissions
   // group 3 is never in the permit field, so it always counts as denied
   // outside debug mode the assigned group passes through unchanged
   wire logic groupDenied = cpuDebugMode & ~group_permitted(permitField, cpuPermissionGroupSel);
   assign busPermissionGroup = (groupDenied & loaded) ? dcw_pkg::DENIED_GROUP
                                                      : cpuPermissionGroupSel;

   // flash power-down in sleep: own bit, else regulator standby
   // no gating by load: before load the word is zero and the regulator
   // standby control alone decides
   assign flashPowerDown = sleepMode & (flashSleepBit | regulatorStandbyCtrl);

   // status word: load done, reserved-ones check, tool bit, effective select
   // bit 6 reads one only when all three reserved bits were programmed
   wire logic [31:0] statusWord = {24'h0, toolBit, &rsvdOnes, 2'h0, dbgSelEff,
                                   cpSticky_reg, loaded};

   // read mux; unmapped offsets read zero
   // registered so the data stand exactly in the cycle after the strobe
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      if (regRead)
      begin
         case (regAddr)
            dcw_pkg::CFG_WORD_OFS: rdata_next = cfgWord_reg;
            dcw_pkg::RT_CTRL_OFS: rdata_next = {28'h0, scanEn_reg, 3'h0};
            dcw_pkg::STATUS_OFS: rdata_next = statusWord;
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // load sequencer; a fresh reset is the only way back to idle
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= DCW_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // held copy of the configuration word
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfgWord_reg <= dcw_pkg::CFG_WORD_RST;
      end
      else
      begin
         cfgWord_reg <= cfgWord_next;
      end
   end

   // code protect strap; reset value keeps the select forced
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cpSticky_reg <= dcw_pkg::CP_STICKY_RST;
      end
      else
      begin
         cpSticky_reg <= cpSticky_next;
      end
   end

   // run-time scan enable bit
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         scanEn_reg <= dcw_pkg::RT_SCAN_EN_RST;
      end
      else
      begin
         scanEn_reg <= scanEn_next;
      end
   end

   // read data register; zero outside the answer cycle
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rdata_reg <= dcw_pkg::RDATA_RST;
      end
      else
      begin
         rdata_reg <= rdata_next;
      end
   end

   // decode register towards core, debug port and flash logic
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         decode_reg <= '0;
      end
      else
      begin
         decode_reg <= decode_next;
      end
   end

   assign regRdata = rdata_reg;
   assign decodeOut = decode_reg;

endmodule // dcw_config_word

// ---- rtl/dcw_pkg.sv ----
// package for the device configuration word decoder
package dcw_pkg;
   // configuration word field positions
   localparam int DBG_PERMIT_HI = 14;
   localparam int DBG_PERMIT_LO = 12;
   localparam int TOOL_RSVD_BIT = 11;
   localparam int FLASH_SLEEP_BIT = 10;
   localparam int RSVD_ONES_HI = 9;
   localparam int RSVD_ONES_LO = 7;
   localparam int BOOT_ISA_BIT = 6;
   localparam int TRACE_EN_BIT = 5;
   localparam int CHAN_SEL_HI = 4;
   localparam int CHAN_SEL_LO = 3;
   localparam int SCAN_FUSE_BIT = 2;
   localparam int DBG_SEL_HI = 1;
   localparam int DBG_SEL_LO = 0;
   // register offsets (byte addresses)
   localparam logic [7:0] CFG_WORD_OFS = 8'h00;
   localparam logic [7:0] RT_CTRL_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   // run-time control layout
   localparam int RT_SCAN_EN_BIT = 3;
   // reset values
   localparam logic [31:0] CFG_WORD_RST = 32'h0000_0000;
   localparam logic RT_SCAN_EN_RST = 1'b0;
   // code protect reads high in reset so debug stays locked down
   localparam logic CP_STICKY_RST = 1'b1;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;
   // permission group used when debug access is denied
   localparam logic [1:0] DENIED_GROUP = 2'h3;
   // core instruction set encodings
   localparam logic [1:0] ISA_STANDARD = 2'h2;
   localparam logic [1:0] ISA_COMPRESSED = 2'h3;
   localparam logic [1:0] DBG_SEL_FORCED = 2'h3;

   // debugger channel pair selection
   typedef enum logic [1:0]
   {
      DCW_CHAN_RSVD = 2'b00,
      DCW_CHAN_PAIR3 = 2'b01,
      DCW_CHAN_PAIR2 = 2'b10,
      DCW_CHAN_PAIR1 = 2'b11
   } dcw_chan_e;

   // decoded fields towards the core, debug port and flash logic
   typedef struct packed
   {
      logic [2:0] debugAccessPermit;
      logic flashSleepPowerdown;
      logic exceptionInstrSetFlag;
      logic [1:0] coreIsaField;
      logic traceEnableBit;
      logic [2:0] twoWireDebugPins;
      logic chanReserved;
      logic fourWireScanEn;
      logic twoWireEn;
      logic inCircuitDebugUnit;
   } dcw_decode_s;
endpackage

// ---- verification/dcw_nv_store.sv ----
// nonvolatile word store standing in for the programming side
`timescale 1ns/100ps
module dcw_nv_store
(
   input wire logic [31:0] progWord,
   output logic [31:0] cfgWord
);
   // programmer forces reserved ones; tool bit passes untouched
   assign cfgWord = progWord | 32'h0000_0380;
endmodule // dcw_nv_store

// ---- verification/dcw_config_word_checker.sv ----
// assertion checker for the configuration word decoder
`timescale 1ns/100ps
module dcw_config_word_checker
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [31:0] cfgWordIn,
   input wire logic codeProtectEn,
   input wire logic cpuDebugMode,
   input wire logic [1:0] cpuPermissionGroupSel,
   input wire logic regulatorStandbyCtrl,
   input wire logic sleepMode,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regRdata,
   input wire logic [1:0] busPermissionGroup,
   input wire logic flashPowerDown,
   input wire dcw_pkg::dcw_decode_s decodeOut
);
   // edges since reset release; the decode is due after the third
   logic [1:0] upCnt;
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         upCnt <= 2'h0;
      end
      else if (upCnt != 2'h3)
      begin
         upCnt <= upCnt + 2'h1;
      end
   end
   wire logic valid = (upCnt == 2'h3);
   wire logic [2:0] permitBits = cfgWordIn[14:12];
   wire logic dny = (cpuPermissionGroupSel == 2'h3) ||
      !permitBits[cpuPermissionGroupSel];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   sequence sLoaded;
      valid;
   endsequence
   // word is held stable after load, so outputs are tied to it directly
   deny_group_a: assert property (sLoaded ##0 (cpuDebugMode && dny) |->
      busPermissionGroup == dcw_pkg::DENIED_GROUP) else $error("denied group not remapped");
   keep_group_a: assert property (sLoaded ##0 !(cpuDebugMode && dny) |->
      busPermissionGroup == cpuPermissionGroupSel) else $error("permitted group altered");
   flash_pd_a: assert property (valid |-> flashPowerDown ==
      (sleepMode && (cfgWordIn[10] || regulatorStandbyCtrl))) else $error("flash power down");
   isa_sel_a: assert property (valid |-> decodeOut.exceptionInstrSetFlag == !cfgWordIn[6]
      && decodeOut.coreIsaField == {1'b1, !cfgWordIn[6]}) else $error("isa decode");
   chan_pair_a: assert property (valid |-> decodeOut.traceEnableBit == cfgWordIn[5] &&
      decodeOut.twoWireDebugPins == {cfgWordIn[4:3] == 2'h1, cfgWordIn[4:3] == 2'h2,
      cfgWordIn[4:3] == 2'h3}) else $error("channel or trace decode");
   scan_block_a: assert property (decodeOut.fourWireScanEn |->
      cfgWordIn[2] && !decodeOut.twoWireEn) else $error("four wire enabled wrongly");
   protect_force_a: assert property (valid && codeProtectEn |->
      !decodeOut.twoWireEn && !decodeOut.inCircuitDebugUnit) else $error("select not forced");
   select_map_a: assert property (valid && !codeProtectEn |->
      decodeOut.twoWireEn == !cfgWordIn[1] && decodeOut.inCircuitDebugUnit == !cfgWordIn[0])
      else $error("debugger select decode");
   read_slot_a: assert property (!$past(regRead) |-> regRdata == 32'h0)
      else $error("read data outside its slot");
endmodule // dcw_config_word_checker
bind dcw_config_word dcw_config_word_checker chk (.*);

// ---- verification/tb_dcw_config_word.sv ----
// self-checking bench for the configuration word decoder
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
   $display("unexpected %0t got %h want %h", $time, (a), (b)); end end
module tb_dcw_config_word;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [31:0] progWord = 32'h0000_0000;
   logic [31:0] cfgWordIn;
   logic codeProtectEn = 1'b0;
   logic cpuDebugMode = 1'b0;
   logic [1:0] cpuPermissionGroupSel = 2'h0;
   logic regulatorStandbyCtrl = 1'b0;
   logic sleepMode = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0000_0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [31:0] regRdata;
   logic [1:0] busPermissionGroup;
   logic flashPowerDown;
   dcw_pkg::dcw_decode_s decodeOut;
   int fails = 0;
   int comparisons = 0;
   // 100 MHz clock
   always #5 clk_sys = ~clk_sys;
   dcw_nv_store store (.progWord(progWord), .cfgWord(cfgWordIn));
   dcw_config_word dut (.*);
   // word changes only inside reset so the capture sees it settled
   task automatic load(input logic [31:0] w, input logic cp);
      @(posedge clk_sys);
      arst_n <= 1'b0;
      progWord <= w;
      codeProtectEn <= cp;
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1;
      `CHK(regRdata, exp)
   endtask
   task automatic t_isa;
      for (int i = 0; i < 2; i++)
      begin
         load({25'h0, i[0], !i[0], 5'h0}, 1'b0);
         `CHK(decodeOut.coreIsaField, {1'b1, !i[0]})
         `CHK(decodeOut.exceptionInstrSetFlag, !i[0])
         `CHK(decodeOut.traceEnableBit, !i[0])
      end
      $display("isa test done");
   endtask
   task automatic t_sel;
      for (int i = 0; i < 4; i++)
      begin
         load({27'h0, i[1:0], 1'b1, i[1:0]}, 1'b0);
         `CHK(decodeOut.twoWireDebugPins, {i[1:0] == 2'h1, i[1:0] == 2'h2, i[1:0] == 2'h3})
         `CHK(decodeOut.chanReserved, i[1:0] == 2'h0)
         `CHK(decodeOut.twoWireEn, !i[1])
         `CHK(decodeOut.inCircuitDebugUnit, !i[0])
         `CHK(decodeOut.fourWireScanEn, i[1])
      end
      load(32'h0000_0804, 1'b1);
      `CHK({decodeOut.twoWireEn, decodeOut.inCircuitDebugUnit}, 2'h0)
      `CHK(decodeOut.fourWireScanEn, 1'b1)
      rdc(dcw_pkg::STATUS_OFS, 32'h0000_00CF);
      $display("select test done");
   endtask
   task automatic t_scan;
      for (int f = 0; f < 2; f++)
      begin
         load({29'h0, f[0], 2'h3}, 1'b0);
         rdc(dcw_pkg::RT_CTRL_OFS, {28'h0, f[0], 3'h0});
         wr(dcw_pkg::RT_CTRL_OFS, 32'h0000_0008);
         rdc(dcw_pkg::RT_CTRL_OFS, {28'h0, f[0], 3'h0});
         wr(dcw_pkg::RT_CTRL_OFS, 32'h0000_0000);
         rdc(dcw_pkg::RT_CTRL_OFS, 32'h0000_0000);
         `CHK(decodeOut.fourWireScanEn, 1'b0)
         wr(dcw_pkg::CFG_WORD_OFS, 32'hFFFF_FFFF);
         rdc(dcw_pkg::CFG_WORD_OFS, {22'h0, 3'h7, 4'h0, f[0], 2'h3});
         rdc(dcw_pkg::STATUS_OFS, 32'h0000_004D);
         rdc(8'h0C, 32'h0000_0000);
      end
      $display("scan test done");
   endtask
   // permit 101 leaves groups 1 and 3 denied
   task automatic t_perm;
      for (int f = 0; f < 2; f++)
      begin
         load({17'h0, 3'h5, 1'b0, f[0], 10'h0}, 1'b0);
         `CHK(decodeOut.debugAccessPermit, 3'h5)
         `CHK(decodeOut.flashSleepPowerdown, f[0])
         for (int g = 0; g < 8; g++)
         begin
            @(posedge clk_sys);
            cpuDebugMode <= g[2];
            cpuPermissionGroupSel <= g[1:0];
            sleepMode <= g[0];
            regulatorStandbyCtrl <= g[1];
            @(posedge clk_sys);
            #1;
            `CHK(busPermissionGroup, (g[2] && g[0]) ? 2'h3 : g[1:0])
            `CHK(flashPowerDown, g[0] && (f[0] || g[1]))
         end
      end
      $display("permission test done");
   endtask
   task automatic summarize;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      t_isa();
      t_sel();
      t_scan();
      t_perm();
      summarize();
   end
   // watchdog far beyond the few hundred cycles the tests take
   initial
   begin
      #200us;
      fails++;
      summarize();
   end
endmodule // tb_dcw_config_word
